/* rtl/bbx_pkg.sv */
// shared constants, types and decode helpers for the bit/branch/call/clear executor
// ============================================================
// Contract
// - bit toggle op inverts one selected bit of the register, flags untouched
// - access flag 0 picks the access bank, 1 uses the bank select register
// - branch on overflow is taken only while the overflow flag is set
// - branch on zero is taken only while the zero flag is set
// - taken branch target is incremented address plus twice signed offset
// - branch takes one cycle untaken, two cycles taken, second is idle
// - call is two words, prefix 1110 110 plus s, then prefix 1111; the code takes any second word and uses its low twelve bits
// - call pushes its own address plus 4 onto the stack top
// - shadow flag 1 copies working, flags and bank select into shadows
// - call loads 20-bit target into pc bits 20..1 in two cycles
// - clear op writes zero to the register and sets zero flag
package bbx_pkg;
    localparam int PC_W     = 21;
    localparam int DATA_W   = 8;
    localparam int BANK_W   = 4;
    localparam int REG_AW   = 4;
    localparam int BUS_W    = 32;
    localparam int STATUS_W = 5;

    // opcode fields
    localparam logic [3:0] OP_TOGGLE = 4'h7;
    localparam logic [7:0] OP_BR_OV  = 8'hE4;
    localparam logic [7:0] OP_BR_Z   = 8'hE0;
    localparam logic [6:0] OP_CALL1  = 7'h76;
    localparam logic [3:0] OP_CALL2  = 4'hF;
    localparam logic [6:0] OP_CLR    = 7'h35;

    // status flag positions
    localparam int ST_C  = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_OV = 3;
    localparam int ST_N  = 4;

    // access bank: low half of bank 0, high half of the top bank
    localparam logic [7:0]        ACC_SPLIT   = 8'h80;
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;

    // register port offsets
    localparam logic [REG_AW-1:0] REG_BANK  = 4'h0;
    localparam logic [REG_AW-1:0] REG_WORK  = 4'h1;
    localparam logic [REG_AW-1:0] REG_STAT  = 4'h2;
    localparam logic [REG_AW-1:0] REG_PC    = 4'h3;
    localparam logic [REG_AW-1:0] REG_TOP   = 4'h4;
    localparam logic [REG_AW-1:0] REG_WSHAD = 4'h5;
    localparam logic [REG_AW-1:0] REG_FSHAD = 4'h6;
    localparam logic [REG_AW-1:0] REG_BSHAD = 4'h7;

    // reset values
    localparam logic [PC_W-1:0]     PC_RST   = 21'h00_0000;
    localparam logic [DATA_W-1:0]   BYTE_RST = 8'h00;
    localparam logic [STATUS_W-1:0] STAT_RST = 5'h00;

    // pc step of one instruction word
    localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;

    typedef enum {OPK_NONE, OPK_TOGGLE, OPK_BR_OV, OPK_BR_Z, OPK_CALL, OPK_CLR} bbx_op_t;
    typedef enum {M_IDLE, M_EXEC, M_NOP, M_WORD2, M_CALL2} bbx_mode_t;

    function automatic bbx_op_t bbx_decode(input logic [15:0] w);
        bbx_op_t k;
        k = OPK_NONE;
        if (w[15:12] == OP_TOGGLE)     k = OPK_TOGGLE;
        else if (w[15:8] == OP_BR_OV)  k = OPK_BR_OV;
        else if (w[15:8] == OP_BR_Z)   k = OPK_BR_Z;
        else if (w[15:9] == OP_CALL1)  k = OPK_CALL;
        else if (w[15:9] == OP_CLR)    k = OPK_CLR;
        return k;
    endfunction : bbx_decode

    function automatic logic [BANK_W+7:0] bbx_addr(input logic acc,
                                                  input logic [7:0] f,
                                                  input logic [BANK_W-1:0] bank);
        logic [BANK_W-1:0] b;
        b = bank;
        if (!acc) b = (f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
        return {b, f};
    endfunction : bbx_addr
endpackage : bbx_pkg

/* rtl/bbx_mem_if.sv */
// data memory port between the executor and its memory
`timescale 1ns/1ps
`default_nettype none
interface bbx_mem_if #(parameter int AW = 12, parameter int DW = 8);
    logic          rd_en;
    logic          wr_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
    modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : bbx_mem_if
`default_nettype wire

/* rtl/bbx_dmem.sv */
// banked data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bbx_dmem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic clk,
    bbx_mem_if.mem    port
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    // contents are not reset; software sees whatever the array held
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (port.rd_en) begin
            port.rdata <= store[port.addr];
        end
    end
endmodule : bbx_dmem
`default_nettype wire

/* rtl/bbx_exec.sv */
// executor for bit toggle, flag branches, subroutine call and register clear
`timescale 1ns/1ps
`default_nettype none
module bbx_exec #(
    parameter int BANKS_W = bbx_pkg::BANK_W
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        instr_valid,
    input  wire logic [15:0]                 instr_word,
    output logic                             instr_ready,
    output logic [1:0]                       q_phase,
    output logic [bbx_pkg::PC_W-1:0]         pc,
    output logic [bbx_pkg::PC_W-1:0]         stack_top,
    output logic                             stack_push,
    input  wire logic [bbx_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [bbx_pkg::BUS_W-1:0]   reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [bbx_pkg::BUS_W-1:0]        reg_rdata
);
    import bbx_pkg::*;

    localparam int AW = BANKS_W + 8;

    // ============================================================
    // elaboration checks
    generate
        if (BANKS_W != BANK_W) begin : g_bad_banks
            $error("bank select width must match the bank field");
        end
    endgenerate

    // ============================================================
    // state
    bbx_mode_t                mode;
    bbx_mode_t                next_mode;
    logic [1:0]               ph;
    logic [1:0]               next_ph;
    logic [15:0]              ir;
    logic [11:0]              k_hi;
    bbx_op_t                  op;
    logic                     taken;
    logic [DATA_W-1:0]        result;
    logic [DATA_W-1:0]        bank_select_register;
    logic [DATA_W-1:0]        work;
    logic [STATUS_W-1:0]      status;
    logic [DATA_W-1:0]        working_shadow;
    logic [STATUS_W-1:0]      flags_shadow;
    logic [DATA_W-1:0]        bank_select_shadow;
    logic [PC_W-1:0]          branch_target;
    logic [PC_W-1:0]          call_target;
    logic                     take_word;
    logic                     reg_op;

    bbx_mem_if #(.AW(AW), .DW(DATA_W)) dm ();

    bbx_dmem #(.AW(AW), .DW(DATA_W)) u_dmem (
        .clk  (clk),
        .port (dm.mem)
    );

    // ============================================================
    // derived terms
    assign take_word = instr_valid && (mode == M_IDLE || mode == M_WORD2);
    assign reg_op    = (op == OPK_TOGGLE) || (op == OPK_CLR);

    // sign extend offset, doubled: pc already points past the branch
    assign branch_target = pc + PC_W'({{12{ir[7]}}, ir[7:0], 1'b0});

    // k<19:8> from word two, k<7:0> from word one, landing at pc<20:1>
    assign call_target = {k_hi, ir[7:0], 1'b0};

    // ============================================================
    // sequencing over the four quarters
    always_comb begin
        next_mode = mode;
        next_ph   = ph;
        case (mode)
            M_IDLE: begin
                if (instr_valid) begin
                    next_mode = M_EXEC;
                    next_ph   = 2'd1;
                end
            end
            M_EXEC: begin
                if (ph == 2'd3) begin
                    next_ph = 2'd0;
                    if (op == OPK_CALL) begin
                        next_mode = M_WORD2;
                    end else if (taken) begin
                        next_mode = M_NOP;
                    end else begin
                        next_mode = M_IDLE;
                    end
                end else begin
                    next_ph = ph + 2'd1;
                end
            end
            M_WORD2: begin
                if (instr_valid) begin
                    next_mode = M_CALL2;
                    next_ph   = 2'd1;
                end
            end
            M_CALL2: begin
                if (ph == 2'd3) begin
                    next_mode = M_IDLE;
                    next_ph   = 2'd0;
                end else begin
                    next_ph = ph + 2'd1;
                end
            end
            M_NOP: begin
                // refill cycle of a taken branch does nothing
                if (ph == 2'd3) begin
                    next_mode = M_IDLE;
                    next_ph   = 2'd0;
                end else begin
                    next_ph = ph + 2'd1;
                end
            end
            default: begin
                next_mode = M_IDLE;
                next_ph   = 2'd0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode        <= M_IDLE;
            ph          <= 2'd0;
            q_phase     <= 2'd0;
            instr_ready <= 1'b0;
        end else begin
            mode        <= next_mode;
            ph          <= next_ph;
            q_phase     <= next_ph;
            instr_ready <= (next_mode == M_IDLE) || (next_mode == M_WORD2);
        end
    end

    // ============================================================
    // quarter 1: decode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ir <= 16'h0000;
            op <= OPK_NONE;
        end else if (take_word && mode == M_IDLE) begin
            ir <= instr_word;
            op <= bbx_decode(instr_word);
        end
    end

    // a second word without the 1111 prefix still completes the call;
    // only its low twelve bits are used
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            k_hi <= 12'h000;
        end else if (take_word && mode == M_WORD2) begin
            k_hi <= instr_word[11:0];
        end
    end

    // ============================================================
    // quarter 2 and 3: read register, evaluate condition; data processed in quarter 4
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dm.rd_en <= 1'b0;
            dm.addr  <= '0;
        end else begin
            dm.rd_en <= (mode == M_EXEC) && (ph == 2'd1) && reg_op;
            dm.addr  <= bbx_addr(ir[8], ir[7:0], bank_select_register[BANK_W-1:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            taken <= 1'b0;
        end else if (mode == M_EXEC && ph == 2'd2) begin
            taken <= ((op == OPK_BR_OV) && status[ST_OV])
                  || ((op == OPK_BR_Z) && status[ST_Z]);
        end else if (mode == M_IDLE) begin
            taken <= 1'b0;
        end
    end

    // read data stand only from the fourth quarter on, so the new byte is
    // formed from them there instead of from the previous read
    always_comb begin
        if (op == OPK_CLR) begin
            result = BYTE_RST;
        end else begin
            result = dm.rdata ^ (DATA_W'(1) << ir[11:9]);
        end
    end

    // ============================================================
    // quarter 4: write register back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dm.wr_en <= 1'b0;
            dm.wdata <= BYTE_RST;
        end else begin
            // write strobe set in the last quarter rises as the next cycle opens; the byte lands at the end of its first quarter
            dm.wr_en <= (mode == M_EXEC) && (ph == 2'd3) && reg_op;
            dm.wdata <= result;
        end
    end

    // ============================================================
    // program counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc <= PC_RST;
        end else if (take_word) begin
            pc <= pc + PC_STEP;
        end else if (mode == M_EXEC && ph == 2'd3 && taken) begin
            pc <= branch_target;
        end else if (mode == M_CALL2 && ph == 2'd3) begin
            pc <= call_target;
        end else if (reg_wr && reg_addr == REG_PC && mode == M_IDLE) begin
            // software may only move the pc between instructions
            pc <= reg_wdata[PC_W-1:0];
        end
    end

    // ============================================================
    // return stack top and shadows
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_top  <= PC_RST;
            stack_push <= 1'b0;
        end else begin
            stack_push <= (mode == M_EXEC) && (ph == 2'd2) && (op == OPK_CALL);
            if (mode == M_EXEC && ph == 2'd2 && op == OPK_CALL) begin
                // pc already points at word two, so one more step gives +4
                stack_top <= pc + PC_STEP;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            working_shadow     <= BYTE_RST;
            flags_shadow       <= STAT_RST;
            bank_select_shadow <= BYTE_RST;
        end else if (mode == M_EXEC && ph == 2'd2 && op == OPK_CALL && ir[8]) begin
            working_shadow     <= work;
            flags_shadow       <= status;
            bank_select_shadow <= bank_select_register;
        end
    end

    // ============================================================
    // software visible core registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bank_select_register <= BYTE_RST;
            work                 <= BYTE_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_BANK) begin
                bank_select_register <= reg_wdata[DATA_W-1:0];
            end
            if (reg_addr == REG_WORK) begin
                work <= reg_wdata[DATA_W-1:0];
            end
        end
    end

    // only the clear op touches a flag; a same cycle software write loses only the zero flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= STAT_RST;
        end else begin
            if (reg_wr && reg_addr == REG_STAT) begin
                status <= reg_wdata[STATUS_W-1:0];
            end
            if (mode == M_EXEC && ph == 2'd3 && op == OPK_CLR) begin
                status[ST_Z] <= 1'b1;
            end
        end
    end

    // ============================================================
    // register read port, answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_BANK:  reg_rdata <= BUS_W'(bank_select_register);
                REG_WORK:  reg_rdata <= BUS_W'(work);
                REG_STAT:  reg_rdata <= BUS_W'(status);
                REG_PC:    reg_rdata <= BUS_W'(pc);
                REG_TOP:   reg_rdata <= BUS_W'(stack_top);
                REG_WSHAD: reg_rdata <= BUS_W'(working_shadow);
                REG_FSHAD: reg_rdata <= BUS_W'(flags_shadow);
                REG_BSHAD: reg_rdata <= BUS_W'(bank_select_shadow);
                default:   reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : bbx_exec
`default_nettype wire

/* verification/bbx_exec_assertions.sv */
// port-level assertions for the executor
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_assertions (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       instr_valid,
    input wire logic                       instr_ready,
    input wire logic [1:0]                 q_phase,
    input wire logic [bbx_pkg::PC_W-1:0]  pc,
    input wire logic [bbx_pkg::PC_W-1:0]  stack_top,
    input wire logic                       stack_push,
    input wire logic                       reg_rd,
    input wire logic [bbx_pkg::BUS_W-1:0] reg_rdata
);
    import bbx_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ====
    // instruction timing
    ready_phase_a: assert property (instr_ready |-> q_phase == 2'h0)
        else $error("ready outside the first quarter");
    phase_step_a: assert property (q_phase != 2'h0 |=> q_phase == $past(q_phase) + 2'h1)
        else $error("quarter did not advance");
    busy_len_a: assert property (instr_valid && instr_ready |=> !instr_ready [*3])
        else $error("instruction cycle shorter than four quarters");
    pc_step_a: assert property (instr_valid && instr_ready |=> pc == $past(pc) + PC_STEP)
        else $error("pc not stepped by one word on take");
    // ====
    // return stack
    push_pulse_a: assert property (stack_push |=> !stack_push)
        else $error("push longer than one cycle");
    push_value_a: assert property (stack_push |-> stack_top == pc + PC_STEP)
        else $error("pushed address is not call address plus 4");
    top_change_a: assert property (stack_top != $past(stack_top) |-> stack_push)
        else $error("stack top moved without a push");
    // ====
    // register port: data only in the cycle after a read
    rdata_idle_a: assert property (reg_rdata != '0 |-> $past(reg_rd))
        else $error("read data outside its cycle");
endmodule : bbx_exec_assertions
bind bbx_exec bbx_exec_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .q_phase(q_phase), .pc(pc),
    .stack_top(stack_top), .stack_push(stack_push), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

/* verification/bit_branch_call_clear_exec_test.sv */
// self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, s); end end
module bit_branch_call_clear_exec_test;
    import bbx_pkg::*;
    logic              clk, sys_rst, instr_valid, instr_ready, stack_push;
    logic              reg_wr, reg_rd, rd_d;
    logic [15:0]       instr_word;
    logic [1:0]        q_phase;
    logic [PC_W-1:0]   pc, stack_top, tgt;
    logic [REG_AW-1:0] reg_addr, cur_a;
    logic [BUS_W-1:0]  reg_wdata, reg_rdata, cur_e;
    logic [BUS_W-1:0]  exp_q[$];
    logic [REG_AW-1:0] adr_q[$];
    logic [7:0]        offs[4], o, wv, bv, shw, shb;
    logic [STATUS_W-1:0] st, sv, shs;
    logic [19:0]       k;
    int                err_count, n_compared, seed, n;
    bbx_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .q_phase(q_phase), .pc(pc),
        .stack_top(stack_top), .stack_push(stack_push), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ====
    // tasks
    task end_of_test;
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task wr(input logic [REG_AW-1:0] a, input logic [BUS_W-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [REG_AW-1:0] a, input logic [BUS_W-1:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        adr_q.push_back(a);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // sampled 1 ns after the edge so the design's updates have landed
    task wait_rdy(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (instr_ready !== 1'b1 && c < 50);
        if (c >= 50) begin
            err_count++;
            end_of_test();
        end
    endtask : wait_rdy
    task issue(input logic [15:0] w, output int c);
        int t;
        wait_rdy(t);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_word  <= ~w;
        wait_rdy(c);
    endtask : issue
    // ====
    // watcher: read data stand in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d === 1'b1) begin
            cur_e = exp_q.pop_front();
            cur_a = adr_q.pop_front();
            `CHK($sformatf("reg %0h", cur_a), cur_e, reg_rdata)
        end
        rd_d <= reg_rd;
    end
    // ====
    // main sequence
    initial begin
        seed = 33;
        err_count = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(i[REG_AW-1:0], 32'h0000_0000);
        rd(4'hF, 32'h0000_0000);
        wr(REG_BANK, 32'h0000_0003);
        issue({OP_CLR, 1'b1, 8'h75}, n);
        `CHK("clear cycles", 3, n)
        rd(REG_STAT, 32'h0000_0004);
        rd(REG_PC, 32'h0000_0002);
        `CHK("cleared byte", 8'h00, dut.u_dmem.store[12'h375])
        wr(REG_STAT, 32'h0000_001B);
        issue({OP_TOGGLE, 3'h4, 1'b1, 8'h75}, n);
        rd(REG_STAT, 32'h0000_001B);
        rd(REG_PC, 32'h0000_0004);
        `CHK("toggled byte", 8'h10, dut.u_dmem.store[12'h375])
        // access bank: low half from bank 0, high half from the top bank
        issue({OP_CLR, 1'b0, 8'h90}, n);
        issue({OP_TOGGLE, 3'h0, 1'b0, 8'h90}, n);
        issue({OP_CLR, 1'b0, 8'h10}, n);
        rd(REG_STAT, 32'h0000_001F);
        `CHK("high access byte", 8'h01, dut.u_dmem.store[12'hF90])
        `CHK("low access byte", 8'h00, dut.u_dmem.store[12'h010])
        // boundary offsets both ways, the other flag set to catch a swapped test
        offs = '{8'h80, 8'h7F, 8'h00, 8'h01};
        offs[3] = 8'($random(seed));
        for (int i = 0; i < 16; i++) begin
            o = offs[i[3:2]];
            st = '0;
            st[(i[1] ^ i[0]) ? ST_OV : ST_Z] = 1'b1;
            wr(REG_STAT, {27'h0, st});
            wr(REG_PC, 32'h0000_1000);
            issue({i[1] ? OP_BR_OV : OP_BR_Z, o}, n);
            tgt = 21'h00_1002 + (i[0] ? 21'h00_0000 : {{12{o[7]}}, o, 1'b0});
            `CHK("branch cycles", i[0] ? 3 : 7, n)
            rd(REG_PC, {11'h0, tgt});
            rd(REG_STAT, {27'h0, st});
        end
        for (int s = 1; s >= 0; s--) begin
            k = 20'($random(seed));
            wv = 8'($random(seed));
            bv = 8'($random(seed));
            sv = STATUS_W'($random(seed));
            wr(REG_WORK, {24'h0, wv});
            wr(REG_BANK, {24'h0, bv});
            wr(REG_STAT, {27'h0, sv});
            wr(REG_PC, 32'h0000_2000);
            issue({OP_CALL1, s[0], k[7:0]}, n);
            `CHK("call first cycles", 3, n)
            issue({OP_CALL2, k[19:8]}, n);
            `CHK("call second cycles", 3, n)
            rd(REG_PC, {11'h0, k, 1'b0});
            rd(REG_TOP, 32'h0000_2004);
            rd(REG_STAT, {27'h0, sv});
            if (s == 1) begin
                shw = wv;
                shb = bv;
                shs = sv;
            end
            rd(REG_WSHAD, {24'h0, shw});
            rd(REG_FSHAD, {27'h0, shs});
            rd(REG_BSHAD, {24'h0, shb});
        end
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule : bit_branch_call_clear_exec_test
`default_nettype wire
